// *** verilog/asr_pkg.sv ***
// constants, types and encodings shared by both ends of the serial readout link
//
// Behaviour
// - chip-select fall samples clock pin, picks mode
// - host holds clock low at select fall in external mode
// - data output released while select high
// - select low shows pending flag, converting/asleep
// - conversion end enters sleep regardless of select
// - sleep keeps result until clock rise, select low
// - pending flag fall loads result register
// - shift on falling edges, sample on rising
// - external mode: 32nd fall starts new conversion
// - external mode: select rise aborts, restarts conversion
// - select tied low: mode picked at power-on end
// - high or floating clock at fall: internal mode
// - internal mode: select low drives clock low
// - internal mode: output starts after status test delay
// - status-only host releases select before delay ends
// - internal mode: 32 rises, then hold high, convert
// - internal mode: select rise aborts, restarts conversion
// - pull-up off while clock pin low
// - host avoids raising select while clock low; status tests and 32-bit external reads raise it with clock low
// - sleep select pulse: clock low, pull-up returns
// - internal serial clock is conversion clock over eight
// - result shifted most significant bit first
package asr_pkg;
   // ****************
   // timing
   // ****************
   localparam int CLK_NS       = 20;
   localparam int FRAME_BITS   = 32;
   localparam int SCK_DIV      = 8;
   localparam int TEST_NS      = 23000;
   localparam int TEST_CYC     = (TEST_NS + CLK_NS - 1) / CLK_NS;
   localparam int EXT_TEST_X10 = 36;
   localparam int EXT_TEST_DIV = 10;
   localparam int CONV_MS      = 133;
   localparam int CONV_CYC_DEF = CONV_MS * 1000000 / CLK_NS;
   localparam int POR_US       = 500;
   localparam int POR_CYC_DEF  = POR_US * 1000 / CLK_NS;
   localparam int DOUT_INT_US  = 1670;
   localparam int OSC_CYC      = DOUT_INT_US * 1000 / (FRAME_BITS * SCK_DIV * CLK_NS);
   localparam logic [1:0] SCK_HALF_M1 = 2'(SCK_DIV / 2 - 1);
   localparam logic [5:0] LAST_BIT    = 6'(FRAME_BITS);
   localparam logic [3:0] HOST_HALF   = 4'h8;
   localparam logic [3:0] SETTLE_CYC  = 4'hA;
   // ****************
   // host registers
   // ****************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam int CTRL_READ    = 0;
   localparam int CTRL_TEST    = 1;
   localparam int CTRL_EXT     = 2;
   localparam int CTRL_LEN_LSB = 8;
   localparam int CTRL_LEN_MSB = 13;
   localparam int STAT_BUSY    = 0;
   localparam int STAT_EOC     = 1;
   localparam int STAT_DONE    = 2;
   localparam logic [5:0] LEN_RST = 6'h20;
   // ****************
   // state encodings
   // ****************
   typedef enum logic [1:0] {
      ST_POR   = 2'h0,
      ST_CONV  = 2'h1,
      ST_SLEEP = 2'h2,
      ST_DOUT  = 2'h3
   } asr_dev_state_type;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_PREP = 3'h1,
      H_WAIT = 3'h2,
      H_LO   = 3'h3,
      H_HI   = 3'h4,
      H_END  = 3'h5
   } asr_host_state_type;
endpackage

// *** verilog/asr_link_if.sv ***
// three-wire serial link between converter and host, with pin resolution
`timescale 1ns/10ps
interface asr_link_if;
   logic cs_n;
   logic host_sck_o;
   logic host_sck_oe_n;
   logic dev_sck_o;
   logic dev_sck_oe_n;
   logic dev_sck_pu;
   logic dev_sdo_o;
   logic dev_sdo_oe_n;
   wire  sck;
   wire  sdo;
   // undriven clock pin follows the weak pull-up, else stays low
   assign sck = !host_sck_oe_n ? host_sck_o : (!dev_sck_oe_n ? dev_sck_o : dev_sck_pu);
   // released data pin has no pull: it shows the inverse of the last value
   assign sdo = !dev_sdo_oe_n ? dev_sdo_o : ~dev_sdo_o;
   modport dev (input cs_n, input sck, output dev_sck_o, output dev_sck_oe_n,
                output dev_sck_pu, output dev_sdo_o, output dev_sdo_oe_n);
   modport host (output cs_n, output host_sck_o, output host_sck_oe_n,
                 input sck, input sdo);
endinterface

// *** verilog/asr_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module asr_sync #(
   parameter int W = 2
) (
   input  wire logic         sys_clk, // system clock
   input  wire logic         rst,     // synchronous reset
   input  wire logic         ce,      // clock enable
   input  wire logic [W-1:0] d,       // asynchronous pins
   output logic      [W-1:0] q        // synchronised copy
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } asr_sync_regs_type;
   asr_sync_regs_type r_q, r_d;
   always_comb begin
      r_d    = r_q;
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_q <= '1;
      end else if (ce) begin
         r_q <= r_d;
      end
   end
   assign q = r_q.s2;
endmodule

// *** verilog/asr_device.sv ***
// converter end: conversion cycle, sleep, result shift and clock mode control
`timescale 1ns/10ps
module asr_device #(
   parameter int CONV_CYCLES = asr_pkg::CONV_CYC_DEF,
   parameter int POR_CYCLES  = asr_pkg::POR_CYC_DEF
) (
   input  wire logic        sys_clk,             // system clock
   input  wire logic        rst,                 // synchronous reset
   input  wire logic        ce,                  // clock enable
   asr_link_if.dev          link,                // serial pins
   input  wire logic [30:0] conv_result,         // result of finished conversion
   input  wire logic        ext_osc_sel,         // conversion clock from outside
   input  wire logic [15:0] external_osc_period, // its period in sys_clk cycles
   output logic             conv_busy,           // conversion in progress
   output logic             sck_mode_ext         // external clock mode chosen
);
   typedef struct packed {
      asr_pkg::asr_dev_state_type st;
      logic                       ext;
      logic                       busy;
      logic                       cs_p;
      logic                       sck_p;
      logic                       pu;
      logic [31:0]                cnt;
      logic [15:0]                tick;
      logic [1:0]                 ph;
      logic [23:0]                tmr;
      logic [5:0]                 bits;
      logic [31:0]                sreg;
      logic                       sdo;
      logic                       sdo_oe_n;
      logic                       sck;
      logic                       sck_oe_n;
   } asr_dev_regs_type;

   asr_dev_regs_type q, n;
   logic [1:0]       sy;
   logic             cs_s;
   logic             sck_s;
   logic             cs_fall;
   logic             cs_rise;
   logic             sck_rise;
   logic             sck_fall;
   logic             tick_en;
   logic [15:0]      osc_cyc;
   logic [23:0]      tdel;

   // ****************
   // pin sampling
   // ****************
   asr_sync #(.W(2)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .d       ({link.cs_n, link.sck}),
      .q       (sy)
   );
   assign cs_s     = sy[1];
   assign sck_s    = sy[0];
   assign cs_fall  = q.cs_p & ~cs_s;
   assign cs_rise  = ~q.cs_p & cs_s;
   assign sck_rise = ~q.sck_p & sck_s;
   assign sck_fall = q.sck_p & ~sck_s;
   assign osc_cyc  = ext_osc_sel ? external_osc_period : 16'(asr_pkg::OSC_CYC);
   assign tdel = ext_osc_sel ?
                 24'((int'(external_osc_period) * asr_pkg::EXT_TEST_X10
                      + asr_pkg::EXT_TEST_DIV - 1) / asr_pkg::EXT_TEST_DIV) :
                 24'(asr_pkg::TEST_CYC);

   // ****************
   // next state
   // ****************
   always_comb begin
      n       = q;
      tick_en = (q.tick == 16'h0000);
      n.tick  = tick_en ? osc_cyc - 16'h0001 : q.tick - 16'h0001;
      n.cs_p  = cs_s;
      n.sck_p = sck_s;
      n.sdo_oe_n = cs_s;
      if (q.st == asr_pkg::ST_POR || sck_rise ||
          (cs_rise && !q.ext && q.st == asr_pkg::ST_SLEEP)) begin
         n.pu = 1'b1;
      end else if (sck_fall) begin
         n.pu = 1'b0;
      end
      if (cs_fall) begin
         n.ext      = ~sck_s;
         n.sck_oe_n = ~sck_s;
         n.sck      = 1'b0;
      end
      if (cs_rise) begin
         n.sck_oe_n = 1'b1;
      end
      unique case (q.st)
         asr_pkg::ST_POR: begin
            n.cnt = q.cnt + 32'h0000_0001;
            if (q.cnt == 32'(POR_CYCLES - 1)) begin
               n.st       = asr_pkg::ST_CONV;
               n.cnt      = 32'h0000_0000;
               n.ext      = ~sck_s;
               n.sck      = 1'b1;
               n.sck_oe_n = cs_s | ~sck_s;
            end
         end
         asr_pkg::ST_CONV: begin
            n.cnt = q.cnt + 32'h0000_0001;
            if (q.cnt == 32'(CONV_CYCLES - 1)) begin
               n.st  = asr_pkg::ST_SLEEP;
               n.sreg = {1'b0, conv_result};
               n.tmr  = 24'h00_0000;
               if (!cs_s && !n.ext) begin
                  n.sck = 1'b0;
               end
            end
         end
         asr_pkg::ST_SLEEP: begin
            if (cs_s) begin
               n.tmr = 24'h00_0000;
            end else if (n.ext) begin
               if (sck_rise) begin
                  n.st   = asr_pkg::ST_DOUT;
                  n.bits = 6'h01;
               end
            end else if (q.tmr >= tdel - 24'h00_0001) begin
               n.st   = asr_pkg::ST_DOUT;
               n.sck  = 1'b1;
               n.bits = 6'h01;
               n.ph   = 2'h0;
            end else begin
               n.tmr = q.tmr + 24'h00_0001;
            end
         end
         asr_pkg::ST_DOUT: begin
            if (cs_rise) begin
               n.st  = asr_pkg::ST_CONV;
               n.cnt = 32'h0000_0000;
            end else if (q.ext) begin
               if (sck_rise) begin
                  n.bits = q.bits + 6'h01;
               end else if (sck_fall) begin
                  if (q.bits == asr_pkg::LAST_BIT) begin
                     n.st  = asr_pkg::ST_CONV;
                     n.cnt = 32'h0000_0000;
                  end else begin
                     n.sreg = {q.sreg[30:0], 1'b0};
                  end
               end
            end else if (tick_en) begin
               n.ph = q.ph + 2'h1;
               if (q.ph == asr_pkg::SCK_HALF_M1) begin
                  if (!q.sck) begin
                     n.sck  = 1'b1;
                     n.bits = q.bits + 6'h01;
                  end else if (q.bits == asr_pkg::LAST_BIT) begin
                     n.st  = asr_pkg::ST_CONV;
                     n.cnt = 32'h0000_0000;
                  end else begin
                     n.sck  = 1'b0;
                     n.sreg = {q.sreg[30:0], 1'b0};
                  end
               end
            end
         end
      endcase
      n.sdo  = (n.st == asr_pkg::ST_CONV || n.st == asr_pkg::ST_POR) ? 1'b1 : n.sreg[31];
      n.busy = (n.st == asr_pkg::ST_CONV);
   end

   // ****************
   // state register
   // ****************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '{st: asr_pkg::ST_POR, cs_p: 1'b1, sck_p: 1'b1, pu: 1'b1, sdo: 1'b1,
                sdo_oe_n: 1'b1, sck: 1'b1, sck_oe_n: 1'b1, default: '0};
      end else if (ce) begin
         q <= n;
      end
   end

   assign link.dev_sdo_o    = q.sdo;
   assign link.dev_sdo_oe_n = q.sdo_oe_n;
   assign link.dev_sck_o    = q.sck;
   assign link.dev_sck_oe_n = q.sck_oe_n;
   assign link.dev_sck_pu   = q.pu;
   assign conv_busy         = q.busy;
   assign sck_mode_ext      = q.ext;
endmodule

// *** verilog/asr_host.sv ***
// host end: Avalon-MM command registers driving status tests and frame reads
`timescale 1ns/10ps
module asr_host (
   input  wire logic        sys_clk,         // system clock
   input  wire logic        rst,             // synchronous reset
   input  wire logic        ce,              // clock enable
   asr_link_if.host         link,            // serial pins
   input  wire logic [3:0]  avs_address,     // byte address
   input  wire logic        avs_read,        // read request
   input  wire logic        avs_write,       // write request
   input  wire logic [31:0] avs_writedata,   // write data
   output logic      [31:0] avs_readdata,    // read data
   output logic             avs_waitrequest  // low when request taken
);
   typedef struct packed {
      asr_pkg::asr_host_state_type st;
      logic                        ext;
      logic                        test;
      logic                        busy;
      logic                        eoc;
      logic                        done;
      logic [5:0]                  len;
      logic [31:0]                 frame;
      logic [3:0]                  cnt;
      logic [5:0]                  bits;
      logic                        cs_n;
      logic                        sck;
      logic                        sck_oe_n;
      logic                        sck_p;
      logic                        ack;
      logic [31:0]                 rdata;
   } asr_host_regs_type;

   asr_host_regs_type q, n;
   logic [1:0]        sy;
   logic              sdo_s;
   logic              sck_rise;
   logic              wr_ctrl;

   asr_sync #(.W(2)) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .d       ({link.sdo, link.sck}),
      .q       (sy)
   );
   assign sdo_s    = sy[1];
   assign sck_rise = ~q.sck_p & sy[0];
   assign wr_ctrl  = q.ack & avs_write & (avs_address == asr_pkg::REG_CTRL);

   always_comb begin
      n       = q;
      n.sck_p = sy[0];
      // ****************
      // bus slave
      // ****************
      n.ack = (avs_read | avs_write) & ~q.ack;
      if (avs_read && !q.ack) begin
         unique case (avs_address)
            asr_pkg::REG_CTRL: begin
               n.rdata = 32'h0000_0000;
               n.rdata[asr_pkg::CTRL_EXT] = q.ext;
               n.rdata[asr_pkg::CTRL_LEN_MSB:asr_pkg::CTRL_LEN_LSB] = q.len;
            end
            asr_pkg::REG_STAT: n.rdata = {29'h0000_0000, q.done, q.eoc, q.busy};
            asr_pkg::REG_DATA: n.rdata = q.frame;
            default:           n.rdata = 32'h0000_0000;
         endcase
      end
      // ****************
      // link sequencer
      // ****************
      unique case (q.st)
         asr_pkg::H_IDLE: begin
            n.cs_n = 1'b1;
            n.sck  = 1'b0;
            if (wr_ctrl) begin
               n.ext = avs_writedata[asr_pkg::CTRL_EXT];
               n.len = avs_writedata[asr_pkg::CTRL_LEN_MSB:asr_pkg::CTRL_LEN_LSB];
               if (avs_writedata[asr_pkg::CTRL_READ] || avs_writedata[asr_pkg::CTRL_TEST]) begin
                  n.st    = asr_pkg::H_PREP;
                  n.test  = ~avs_writedata[asr_pkg::CTRL_READ];
                  n.busy  = 1'b1;
                  n.done  = 1'b0;
                  n.cnt   = 4'h0;
                  n.bits  = 6'h00;
                  n.frame = 32'h0000_0000;
               end
            end
         end
         asr_pkg::H_PREP: begin
            n.sck_oe_n = ~q.ext;
            n.cnt      = q.cnt + 4'h1;
            if (q.cnt == asr_pkg::SETTLE_CYC) begin
               n.cs_n = 1'b0;
               n.cnt  = 4'h0;
               n.st   = asr_pkg::H_WAIT;
            end
         end
         asr_pkg::H_WAIT: begin
            if (q.cnt != asr_pkg::SETTLE_CYC) begin
               n.cnt = q.cnt + 4'h1;
            end else if (q.test) begin
               n.eoc = sdo_s;
               n.st  = asr_pkg::H_END;
            end else if (q.ext) begin
               if (!sdo_s) begin
                  n.cnt = 4'h0;
                  n.st  = asr_pkg::H_LO;
               end
            end else if (sck_rise) begin
               n.frame = {q.frame[30:0], sdo_s};
               n.bits  = q.bits + 6'h01;
               // release select only with clock high
               if (n.bits == q.len || n.bits == asr_pkg::LAST_BIT) begin
                  n.st = asr_pkg::H_END;
               end
            end
         end
         asr_pkg::H_LO: begin
            n.cnt = q.cnt + 4'h1;
            if (q.cnt == asr_pkg::HOST_HALF) begin
               n.sck   = 1'b1;
               n.frame = {q.frame[30:0], sdo_s};
               n.bits  = q.bits + 6'h01;
               n.cnt   = 4'h0;
               n.st    = asr_pkg::H_HI;
            end
         end
         asr_pkg::H_HI: begin
            n.cnt = q.cnt + 4'h1;
            if (q.cnt == asr_pkg::HOST_HALF) begin
               n.cnt = 4'h0;
               if (q.bits == q.len && q.len != asr_pkg::LAST_BIT) begin
                  n.st = asr_pkg::H_END;
               end else begin
                  n.sck = 1'b0;
                  n.st  = (q.bits == asr_pkg::LAST_BIT) ? asr_pkg::H_END : asr_pkg::H_LO;
               end
            end
         end
         asr_pkg::H_END: begin
            n.cs_n = 1'b1;
            n.busy = 1'b0;
            n.done = 1'b1;
            n.st   = asr_pkg::H_IDLE;
         end
         default: begin
            n.st = asr_pkg::H_IDLE;
         end
      endcase
      if (n.st == asr_pkg::H_IDLE) begin
         n.sck_oe_n = ~n.ext;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '{st: asr_pkg::H_IDLE, len: asr_pkg::LEN_RST, cs_n: 1'b1,
                sck_oe_n: 1'b1, sck_p: 1'b1, default: '0};
      end else if (ce) begin
         q <= n;
      end
   end

   assign link.cs_n          = q.cs_n;
   assign link.host_sck_o    = q.sck;
   assign link.host_sck_oe_n = q.sck_oe_n;
   assign avs_readdata       = q.rdata;
   assign avs_waitrequest    = ~q.ack;
endmodule

// *** dv/asr_link_monitor.sv ***
// concurrent checks on the serial link between converter and host
`timescale 1ns/10ps
module asr_link_monitor #(
   parameter int CONV_CYCLES = 300
) (
   input wire logic sys_clk,      // system clock
   input wire logic rst,          // synchronous reset
   input wire logic cs_n,         // select pin
   input wire logic sck,          // resolved clock pin
   input wire logic dev_sck_oe_n, // device drives clock when low
   input wire logic dev_sdo_o,    // device data value
   input wire logic dev_sdo_oe_n, // device drives data when low
   input wire logic conv_busy,    // conversion running
   input wire logic sck_mode_ext  // external clock mode
);
   localparam int C_LO = CONV_CYCLES - 2;
   localparam int C_HI = CONV_CYCLES + 2;
   logic [15:0] busy_len_q;
   logic        cs_n_q;
   logic        sck_q;
   logic        rd_seen_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ****************
   // helper state
   // ****************
   // rd_seen_q marks a readout begun by a clock rise with select low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_len_q <= 16'h0000;
         cs_n_q     <= 1'b1;
         sck_q      <= 1'b1;
         rd_seen_q  <= 1'b0;
      end else begin
         busy_len_q <= conv_busy ? busy_len_q + 16'h0001 : 16'h0000;
         cs_n_q     <= cs_n;
         sck_q      <= sck;
         if (conv_busy || cs_n_q) begin
            rd_seen_q <= 1'b0;
         end else if (!cs_n && sck && !sck_q) begin
            rd_seen_q <= 1'b1;
         end
      end
   end
   // ****************
   // properties
   // ****************
   property p_sdo_off;
      cs_n [*5] |-> dev_sdo_oe_n;
   endproperty
   property p_sdo_on;
      !cs_n [*5] |-> !dev_sdo_oe_n;
   endproperty
   property p_busy_flag;
      conv_busy && $past(conv_busy) && !dev_sdo_oe_n && !$past(dev_sdo_oe_n) |-> dev_sdo_o;
   endproperty
   property p_conv_len;
      $fell(conv_busy) |-> busy_len_q >= 16'(C_LO) && busy_len_q <= 16'(C_HI);
   endproperty
   property p_restart_flag;
      $rose(conv_busy) && !cs_n && !dev_sdo_oe_n |-> ##[0:2] dev_sdo_o;
   endproperty
   property p_abort;
      $rose(cs_n) && rd_seen_q |-> ##[1:400] conv_busy;
   endproperty
   property p_int_sck_low;
      !cs_n [*6] ##0 (!sck_mode_ext && !conv_busy) |-> !dev_sck_oe_n;
   endproperty
   property p_mode_pick;
      $fell(cs_n) |-> ##5 (sck_mode_ext == !$past(sck, 5));
   endproperty
   a_sdo_off: assert property (p_sdo_off) else $error("data driven with select high");
   a_sdo_on: assert property (p_sdo_on) else $error("data not driven with select low");
   a_busy_flag: assert property (p_busy_flag) else $error("flag low while converting");
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   a_restart_flag: assert property (p_restart_flag) else $error("no flag at restart");
   a_abort: assert property (p_abort) else $error("readout abort did not convert");
   a_int_sck_low: assert property (p_int_sck_low) else $error("clock not driven");
   a_mode_pick: assert property (p_mode_pick) else $error("clock mode wrong");
   c_ext_full: cover property ($rose(conv_busy) && !cs_n);
   c_abort: cover property ($rose(cs_n) && rd_seen_q);
   c_int_drive: cover property (!cs_n && !sck_mode_ext && !dev_sck_oe_n);
endmodule

// *** dv/tb_adc_serial_readout_interface.sv ***
// self-checking bench: host and converter joined over the serial link
`timescale 1ns/10ps
module tb_adc_serial_readout_interface;
   logic        sys_clk;
   logic        rst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [30:0] conv_result;
   logic        conv_busy;
   logic        sck_mode_ext;
   logic        ce;
   logic        osc_sel;
   logic [15:0] osc_per;
   logic [31:0] rng;
   logic [30:0] res;
   logic [63:0] ent;
   logic [31:0] d;
   logic [5:0]  lens [5];
   logic [63:0] exp_q [$];
   int          n_errors;
   int          checks;
   int          cyc;
   asr_link_if link ();
   asr_device #(.CONV_CYCLES(300), .POR_CYCLES(20)) u_asr_device (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .link(link), .conv_result(conv_result),
      .ext_osc_sel(osc_sel), .external_osc_period(osc_per), .conv_busy(conv_busy),
      .sck_mode_ext(sck_mode_ext));
   asr_host u_asr_host (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .link(link), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   asr_link_monitor #(.CONV_CYCLES(300)) u_asr_link_monitor (
      .sys_clk(sys_clk), .rst(rst), .cs_n(link.cs_n), .sck(link.sck),
      .dev_sck_oe_n(link.dev_sck_oe_n), .dev_sdo_o(link.dev_sdo_o),
      .dev_sdo_oe_n(link.dev_sdo_oe_n), .conv_busy(conv_busy), .sck_mode_ext(sck_mode_ext));
   always #10 sys_clk = ~sys_clk;
   // ****************
   // tasks
   // ****************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic av_wr(input logic [3:0] a, input logic [31:0] wd);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= 1'b1;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // mask zero marks a poll whose value is not judged
   task automatic av_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                        output logic [31:0] rd);
      exp_q.push_back({e, m});
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic run(input logic [31:0] cmd);
      logic [31:0] s;
      av_wr(asr_pkg::REG_CTRL, cmd);
      s = 32'h0;
      while (!(s[asr_pkg::STAT_DONE] === 1'b1 && s[asr_pkg::STAT_BUSY] === 1'b0)) begin
         av_rd(asr_pkg::REG_STAT, 32'h0, 32'h0, s);
      end
   endtask
   task automatic frame(input logic [5:0] len, input logic ext, input logic keep);
      logic [31:0] full;
      int n;
      if (!keep) begin
         rng = xs(rng);
         conv_result <= rng[30:0];
         res = rng[30:0];
      end
      run({18'h0, len, 5'h0, ext, 2'h1});
      n = (len == 6'h0 || len > 6'h20) ? 32 : int'(len);
      full = {1'b0, res};
      av_rd(asr_pkg::REG_DATA, full >> (32 - n), 32'hFFFFFFFF, d);
      av_rd(asr_pkg::REG_STAT, 32'h4, 32'h5, d);
      $display("test frame len %0d ext %0b done", len, ext);
   endtask
   task automatic stat_test(input logic ext, input logic flag);
      run({18'h0, 6'h20, 5'h0, ext, 2'h2});
      av_rd(asr_pkg::REG_STAT, {29'h0, 1'b1, flag, 1'b0}, 32'h7, d);
      $display("test status ext %0b flag %0b done", ext, flag);
   endtask
   // ****************
   // result watcher and timeout
   // ****************
   always @(posedge sys_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         ent = exp_q.pop_front();
         if (ent[31:0] != 32'h0) begin
            check(avs_readdata & ent[31:0], ent[63:32] & ent[31:0]);
         end
      end
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         wrap_up();
      end
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      conv_result = 31'h0;
      ce = 1'b1;
      osc_sel = 1'b1;
      osc_per = 16'h0008;
      rng = 32'h7830126B;
      res = 31'h0;
      n_errors = 0;
      checks = 0;
      cyc = 0;
      lens = '{6'h20, 6'h01, 6'h1F, 6'h00, 6'h3F};
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      av_rd(asr_pkg::REG_CTRL, 32'h00002000, 32'hFFFFFFFF, d);
      av_wr(4'hC, 32'hFFFFFFFF);
      av_rd(4'hC, 32'h0, 32'hFFFFFFFF, d);
      av_wr(asr_pkg::REG_STAT, 32'hFFFFFFFF);
      av_rd(asr_pkg::REG_STAT, 32'h0, 32'h7, d);
      $display("test registers done");
      // internal clock picked at power-on end with the pin released
      frame(6'h20, 1'b0, 1'b0);
      repeat (400) @(posedge sys_clk);
      stat_test(1'b0, 1'b0);
      frame(6'h20, 1'b0, 1'b1);
      // slower conversion clock stretches the internal serial clock
      osc_per <= 16'h000C;
      frame(6'h08, 1'b0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         frame(lens[i], 1'b1, 1'b0);
      end
      stat_test(1'b1, 1'b1);
      repeat (400) @(posedge sys_clk);
      stat_test(1'b1, 1'b0);
      frame(6'h20, 1'b1, 1'b1);
      wrap_up();
   end
endmodule
